// ---- design/hpp_host_port.sv ----
// host access port: parallel bus or serial interface onto a register memory
//
// Overview of operation
// [RULE1] data bus released whenever chip select is high
// [RULE2] serial swap low sends lsb first, high sends msb first
// [RULE3] swap pin only matters in serial mode; otherwise it is data bit 5
// [RULE4] r/w and b flags keep position; only address and data reorder
// [RULE5] host supplies serial clock on data bit 2 pin; device only receives
// [RULE6] data bit 1 pin becomes serial data input, sampled by device
// [RULE7] device drives serial data output on data bit 0 pin
// [RULE8] read and write strobes ignored unless chip select low
// [RULE9] read strobe and chip select low drive addressed register on bus
// [RULE10] parallel write captured at rising edge of write strobe
// [RULE11] serial select low picks parallel mode, high picks serial mode
// [RULE12] data bits 7 and 6 give serial clock polarity and phase
// [RULE13] device reset low clears the whole port and all registers
// [RULE14] parallel output enable only during qualified parallel read
`timescale 1ns/1ps
module hpp_host_port
  import hpp_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic                       device_reset_n,
  input  wire logic                       serial_select,
  input  wire logic                       chip_select_n,
  input  wire logic                       read_strobe_n,
  input  wire logic                       write_strobe_n,
  input  wire logic [hpp_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [hpp_pkg::DATA_W-1:0] data_in,
  output logic      [hpp_pkg::DATA_W-1:0] data_out,
  output logic      [hpp_pkg::DATA_W-1:0] data_oe,
  output logic                            serial_clock_polarity,
  output logic                            serial_clock_phase
);
  import hpp_pkg::*;

  // ---------------------------------------
  // pin synchronisers (two flops each)
  // ---------------------------------------
  localparam int SW = 5 + ADDR_W + DATA_W;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1 <= {5'h1F, {ADDR_W{1'b0}}, {DATA_W{1'b0}}};
      sync2 <= {5'h1F, {ADDR_W{1'b0}}, {DATA_W{1'b0}}};
    end else begin
      sync1 <= {device_reset_n, ~serial_select, chip_select_n, read_strobe_n, write_strobe_n, addr_in, data_in};
      sync2 <= sync1;
    end
  end

  logic              s_rstn;
  logic              s_par;
  logic              s_cs_n;
  logic              s_rd_n;
  logic              s_wr_n;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_data;
  assign {s_rstn, s_par, s_cs_n, s_rd_n, s_wr_n, s_addr, s_data} = sync2;
  logic s_ser;
  assign s_ser = ~s_par;                     // [RULE11]

  // combined internal reset
  logic srst;
  assign srst = !rst_n || !s_rstn;           // [RULE13]

  // serial pins carved from the data bus
  logic s_sclk;
  logic s_mosi;
  logic s_swap;
  assign s_sclk = s_data[POS_SCLK];          // [RULE5]
  assign s_mosi = s_data[POS_MOSI];          // [RULE6]
  assign s_swap = s_data[POS_SWAP];          // [RULE3]

  // function: reverse bit order of a byte
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) r[i] = v[7-i];
    return r;
  endfunction : rev8

  // --------------------------------
  // edge history of write strobe and serial clock
  // --------------------------------
  logic wr_d;
  logic sclk_d;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_d   <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      wr_d   <= s_wr_n;
      sclk_d <= s_sclk;
    end
  end

  // serial mode clock setup latched while chip select high
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      serial_clock_polarity <= 1'b0;         // [RULE12]
      serial_clock_phase    <= 1'b0;
    end else if (s_ser && s_cs_n) begin
      serial_clock_polarity <= s_data[POS_CPOL];
      serial_clock_phase    <= s_data[POS_CPHA];
    end
  end

  // sample and shift edges derived from polarity and phase
  logic lead_edge;
  logic trail_edge;
  logic samp_edge;
  logic shft_edge;
  assign lead_edge  = (s_sclk != sclk_d) && (s_sclk != serial_clock_polarity);
  assign trail_edge = (s_sclk != sclk_d) && (s_sclk == serial_clock_polarity);
  assign samp_edge  = serial_clock_phase ? trail_edge : lead_edge;
  assign shft_edge  = serial_clock_phase ? lead_edge : trail_edge;

  // ------------------------
  // serial frame engine
  // ------------------------
  hpp_state_t        state;
  logic [CNT_W-1:0]  bit_cnt;
  logic              rw_flag;
  logic              b_flag;
  logic [ADDR_W-1:0] sh_addr;
  logic [DATA_W-1:0] sh_data;
  logic [DATA_W-1:0] tx_data;
  logic              ser_act;
  assign ser_act = s_ser && !s_cs_n;         // [RULE8]

  always_ff @(posedge sys_clk) begin
    if (srst || !ser_act) begin
      state   <= HPP_IDLE;
      bit_cnt <= '0;
      rw_flag <= 1'b0;
      b_flag  <= 1'b0;
      sh_addr <= '0;
      sh_data <= '0;
    end else if (samp_edge) begin
      bit_cnt <= bit_cnt + 5'h01;
      unique case (state)
        HPP_IDLE: begin
          rw_flag <= s_mosi;                 // [RULE4]
          state   <= HPP_HEAD;
        end
        HPP_HEAD: begin
          if (bit_cnt == 5'h01) b_flag <= s_mosi; // [RULE4]
          else sh_addr <= {sh_addr[ADDR_W-2:0], s_mosi};
          if (bit_cnt == CNT_ADDR_END - 5'h01) state <= HPP_DATA;
        end
        HPP_DATA: begin
          sh_data <= {sh_data[DATA_W-2:0], s_mosi};
          if (bit_cnt == CNT_FRAME_END - 5'h01) state <= HPP_DONE;
        end
        HPP_DONE: state <= HPP_DONE;
      endcase
    end
  end

  // received address in true order; shift gathered msb first
  logic [ADDR_W-1:0] ser_addr;
  logic [DATA_W-1:0] ser_wdata;
  assign ser_addr  = s_swap ? sh_addr : rev8(sh_addr);  // [RULE2]
  assign ser_wdata = s_swap ? sh_data : rev8(sh_data);  // [RULE2]

  // serial write pulse when last data bit lands
  logic ser_wr;
  assign ser_wr = ser_act && (state == HPP_DONE) && !rw_flag && bit_cnt == CNT_FRAME_END; // [RULE8]

  // --------------------------------------
  // register memory and access decode
  // --------------------------------------
  logic              par_wr;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic              wr_done;
  assign par_wr  = s_par && !s_cs_n && s_wr_n && !wr_d;   // [RULE10]
  assign wr_en   = (par_wr || ser_wr) && !wr_done;
  assign wr_addr = s_par ? s_addr : ser_addr;
  assign wr_data = s_par ? s_data : ser_wdata;

  // one write per serial frame
  always_ff @(posedge sys_clk) begin
    if (srst || !ser_act) wr_done <= 1'b0;
    else if (ser_wr)      wr_done <= 1'b1;
  end

  hpp_regmem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
    .sys_clk (sys_clk),
    .rst_n   (!srst),                        // [RULE13]
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (s_par ? s_addr : ser_addr),    // [RULE9]
    .rd_data (rd_data)
  );

  // load read data into transmit shifter after address phase
  logic [DATA_W-1:0] tx_order;
  assign tx_order = s_swap ? rd_data : rev8(rd_data);
  always_ff @(posedge sys_clk) begin
    if (srst || !ser_act)                                  tx_data <= '0;
    else if (state == HPP_DATA && bit_cnt == CNT_ADDR_END && !samp_edge && sh_data == '0 && !shft_edge)
      tx_data <= tx_order;                                 // [RULE2]
    // the shift edge that closes the address phase must not drop the freshly loaded first bit
    else if (state == HPP_DATA && shft_edge && bit_cnt != CNT_ADDR_END)
      tx_data <= {tx_data[DATA_W-2:0], 1'b0};
  end

  // --------------------------------
  // pin drivers, all from flops
  // --------------------------------
  logic par_rd;
  assign par_rd = s_par && !s_cs_n && !s_rd_n && chip_select_n == 1'b0; // [RULE8]
  always_ff @(posedge sys_clk) begin
    if (srst || chip_select_n) begin
      data_oe  <= '0;                        // [RULE1]
      data_out <= '0;
    end else if (par_rd) begin
      data_oe  <= '1;                        // [RULE14]
      data_out <= rd_data;                   // [RULE9]
    end else if (ser_act && rw_flag && state == HPP_DATA) begin
      data_oe  <= 8'h01;                     // [RULE7]
      data_out <= {7'h00, tx_data[DATA_W-1]};
    end else begin
      data_oe  <= '0;
      data_out <= '0;
    end
  end

  // ---------------------
  // checks
  // ---------------------
  sequence cs_high_s; chip_select_n; endsequence
  sequence rd_q_s; s_par && !s_cs_n && !s_rd_n; endsequence
  release_cs_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cs_high_s |=> data_oe == '0) else $error("bus driven with chip select high"); // [RULE1]
  drive_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    rd_q_s and !chip_select_n |=> data_oe == 8'hFF) else $error("read not driven"); // [RULE9]
  oe_only_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_oe == 8'hFF |-> $past(s_par) && !$past(s_rd_n)) else $error("oe outside read"); // [RULE14]
  miso_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_oe == 8'h01 |-> $past(s_ser)) else $error("miso outside serial"); // [RULE7]
  wr_qual_a: assert property (@(posedge sys_clk) disable iff (srst)
    wr_en |-> !s_cs_n) else $error("unqualified write"); // [RULE8]
  wr_edge_a: assert property (@(posedge sys_clk) disable iff (srst)
    wr_en && s_par |-> !wr_d && s_wr_n) else $error("write not on rising strobe"); // [RULE10]
  cfg_reset_a: assert property (@(posedge sys_clk)
    !rst_n |=> !serial_clock_polarity && !serial_clock_phase) else $error("cfg not reset"); // [RULE12]
  frame_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ser_act |=> state == HPP_IDLE && bit_cnt == '0) else $error("frame not cleared"); // [RULE4]
endmodule : hpp_host_port

// ---- design/hpp_pkg.sv ----
// package of constants for the host port block
package hpp_pkg;
  localparam int ADDR_W          = 8;
  localparam int DATA_W          = 8;
  localparam int REG_DEPTH       = 256;
  localparam int CTRL_BITS       = 2;           // r/w flag then b flag
  localparam int FRAME_BITS      = CTRL_BITS + ADDR_W + DATA_W;
  localparam int CNT_W           = 5;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int POS_SCLK        = 2;
  localparam int POS_MOSI        = 1;
  localparam int POS_MISO        = 0;
  localparam int POS_SWAP        = 5;
  localparam int POS_CPOL        = 7;
  localparam int POS_CPHA        = 6;
  localparam logic [4:0] CNT_ADDR_END = 5'h0A;  // bits before data phase
  localparam logic [4:0] CNT_FRAME_END = 5'h12;
  typedef enum logic [1:0] {
    HPP_IDLE = 2'b00,
    HPP_HEAD = 2'b01,
    HPP_DATA = 2'b11,
    HPP_DONE = 2'b10
  } hpp_state_t;
endpackage : hpp_pkg

// ---- design/hpp_regmem.sv ----
// small register memory with registered read data
`timescale 1ns/1ps
module hpp_regmem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];

  // -----------------------------
  // storage, cleared by reset
  // -----------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 2**AW; i++) mem[i] <= '0;
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge sys_clk) begin
    if (!rst_n) rd_data <= '0;
    else        rd_data <= mem[rd_addr];
  end
endmodule : hpp_regmem

// ---- sim/hpp_host_model.sv ----
// host processor model: parallel bus cycles and serial frames
`timescale 1ns/1ps
module hpp_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_oe,
  output logic            serial_select,
  output logic            chip_select_n,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic [7:0]      addr_in,
  output logic [7:0]      data_in
);
  // wait n edges, then move pins a little later
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // reverse the bit order of a byte
  function automatic logic [7:0] rev8(input logic [7:0] x);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = x[7-i];
    end
  endfunction : rev8

  // pins idle with the port deselected
  initial begin
    serial_select  = 1'b0;
    chip_select_n  = 1'b1;
    read_strobe_n  = 1'b1;
    write_strobe_n = 1'b1;
    addr_in        = 8'h00;
    data_in        = 8'h00;
  end

  // pick port type and set shared pins while deselected
  task automatic set_mode(input logic ser, input logic [7:0] pins);
    serial_select = ser;
    data_in       = pins;
    tick(6);
  endtask : set_mode

  // parallel write; oe sampled while the strobe is low
  task automatic par_write(input logic cs_n, input logic [7:0] a, input logic [7:0] d,
                           output logic [7:0] oe);
    chip_select_n  = cs_n;
    addr_in        = a;
    data_in        = d;
    write_strobe_n = 1'b0;
    tick(4);
    oe             = data_oe;
    write_strobe_n = 1'b1;
    tick(4);
    chip_select_n  = 1'b1;
    data_in        = ~d;
    tick(3);
  endtask : par_write

  // parallel read; also samples oe after release
  task automatic par_read(input logic cs_n, input logic [7:0] a, output logic [7:0] d,
                          output logic [7:0] oe, output logic [7:0] oe_idle);
    chip_select_n = cs_n;
    addr_in       = a;
    read_strobe_n = 1'b0;
    tick(6);
    d             = data_out;
    oe            = data_oe;
    read_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    tick(4);
    oe_idle       = data_oe;
  endtask : par_read

  // serial frame, mode 0: flags, then address and data in swap order
  task automatic spi_frame(input logic rw, input logic swap, input logic [7:0] a, input logic [7:0] d,
                           output logic [7:0] oe_seen, output logic [7:0] miso_rd);
    logic [17:0] f;
    logic [7:0]  r;
    f       = {swap ? rev8(d) : d, swap ? rev8(a) : a, 1'b0, rw};
    oe_seen = 8'h00;
    r       = 8'h00;
    data_in = {2'b00, swap, 5'h00};
    tick(4);
    chip_select_n = 1'b0;
    for (int i = 0; i < 18; i++) begin
      data_in[1] = f[i];
      tick(4);
      // serial output is taken just before the rising clock, as a mode 0 host does
      r          = (i >= 10) ? {r[6:0], data_out[0]} : r;
      data_in[2] = 1'b1;
      tick(4);
      oe_seen    = oe_seen | data_oe;
      data_in[2] = 1'b0;
    end
    miso_rd = swap ? r : rev8(r);
    tick(4);
    chip_select_n = 1'b1;
    data_in[1]    = ~data_in[1];
    tick(4);
  endtask : spi_frame
endmodule : hpp_host_model

// ---- sim/host_port_parallel_serial_tb.sv ----
// testbench for the host port with a host model
`timescale 1ns/1ps
module host_port_parallel_serial_tb;
  logic       sys_clk, rst_n, device_reset_n, serial_select, chip_select_n;
  logic       read_strobe_n, write_strobe_n, serial_clock_polarity, serial_clock_phase;
  logic [7:0] addr_in, data_in, data_out, data_oe, a, d, rd, oe, oe_idle;
  logic [7:0] mem [256];
  int         n_mismatch = 0;
  int         checks     = 0;
  int         cycles     = 0;
  integer     seed       = 32'hb20d;

  hpp_host_port u_hpp_host_port (
    .sys_clk              (sys_clk),
    .rst_n                (rst_n),
    .device_reset_n       (device_reset_n),
    .serial_select        (serial_select),
    .chip_select_n        (chip_select_n),
    .read_strobe_n        (read_strobe_n),
    .write_strobe_n       (write_strobe_n),
    .addr_in              (addr_in),
    .data_in              (data_in),
    .data_out             (data_out),
    .data_oe              (data_oe),
    .serial_clock_polarity(serial_clock_polarity),
    .serial_clock_phase   (serial_clock_phase)
  );

  hpp_host_model u_hpp_host_model (
    .sys_clk       (sys_clk),
    .data_out      (data_out),
    .data_oe       (data_oe),
    .serial_select (serial_select),
    .chip_select_n (chip_select_n),
    .read_strobe_n (read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .addr_in       (addr_in),
    .data_in       (data_in)
  );

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // expected register contents from the shadow copy
  function automatic logic [7:0] exp_rd(input logic [7:0] ad);
    return mem[ad];
  endfunction : exp_rd

  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // cut a hang short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // main sequence
  initial begin
    rst_n          = 1'b0;
    device_reset_n = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n          = 1'b1;
    device_reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    check("oe_reset", data_oe, 8'h00);
    check("cfg_reset", {6'h00, serial_clock_polarity, serial_clock_phase}, 8'h00);
    // random parallel traffic, some deselected, first at both address ends
    for (int i = 0; i < 24; i++) begin
      a = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      d = 8'($random(seed));
      u_hpp_host_model.par_write(i % 4 == 3, a, d, oe);
      check("write_oe", oe, 8'h00);
      if (i % 4 != 3) mem[a] = d;
      u_hpp_host_model.par_read(i % 4 == 1, a, rd, oe, oe_idle);
      if (i % 4 != 1) check("read_data", rd, exp_rd(a));
      check("read_oe", oe, (i % 4 == 1) ? 8'h00 : 8'hFF);
      check("idle_oe", oe_idle, 8'h00);
    end
    // serial mode: config latch, then frames in both bit orders
    u_hpp_host_model.set_mode(1'b1, 8'hC0);
    check("cfg_latch", {6'h00, serial_clock_polarity, serial_clock_phase}, 8'h03);
    for (int s = 0; s < 4; s++) begin
      a = 8'($random(seed));
      d = 8'($random(seed));
      u_hpp_host_model.set_mode(1'b1, 8'h00);
      u_hpp_host_model.spi_frame(1'b0, s[0], a, d, oe, rd);
      check("spi_write_oe", oe, 8'h00);
      mem[a] = d;
      u_hpp_host_model.spi_frame(1'b1, s[0], a, 8'h00, oe, rd);
      check("spi_read_oe", oe, 8'h01);
      check("spi_read_data", rd, exp_rd(a));
      u_hpp_host_model.set_mode(1'b0, 8'h00);
      u_hpp_host_model.par_read(1'b0, a, rd, oe, oe_idle);
      check("spi_write_data", rd, exp_rd(a));
    end
    // device reset clears the registers
    device_reset_n = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    device_reset_n = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (4) @(posedge sys_clk);
    #1;
    u_hpp_host_model.par_read(1'b0, a, rd, oe, oe_idle);
    check("reset_clears", rd, exp_rd(a));
    end_of_test();
  end
endmodule : host_port_parallel_serial_tb
